// ---- design/dfa_pkg.sv ----
// Shared constants and types for the full address DMA channel
package dfa_pkg;

    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int CNT_W = 16;
    localparam int HALF_W = 16;
    localparam int BUS_W = 32;
    localparam int RSV_W = 8;
    localparam int REG_AW = 4;
    localparam int BLK_W = 8;
    localparam int FIFO_DEPTH = 4;

    // Register word indices; byte address is four times the index
    localparam logic [REG_AW-1:0] REG_SRC_LO = 4'h0;
    localparam logic [REG_AW-1:0] REG_SRC_HI = 4'h1;
    localparam logic [REG_AW-1:0] REG_DST_LO = 4'h2;
    localparam logic [REG_AW-1:0] REG_DST_HI = 4'h3;
    localparam logic [REG_AW-1:0] REG_COUNT = 4'h4;
    localparam logic [REG_AW-1:0] REG_IO_ADDR = 4'h5;
    localparam logic [REG_AW-1:0] REG_CTRL = 4'h6;
    localparam logic [REG_AW-1:0] REG_STATUS = 4'h7;

    // Control register bit positions
    localparam int CTL_START = 0;
    localparam int CTL_SRC_DEC = 1;
    localparam int CTL_DST_DEC = 2;
    localparam int CTL_WORD = 3;
    localparam int CTL_FULL = 4;
    localparam int CTL_BLOCK = 5;
    localparam int CTL_ATS = 6;

    // Status register bit positions
    localparam int STS_BUSY = 0;
    localparam int STS_DONE = 1;

    localparam logic [ADDR_W-1:0] STEP_BYTE = 24'h000001;
    localparam logic [ADDR_W-1:0] STEP_WORD = 24'h000002;

    typedef struct packed {
        logic ack_timing_select;
        logic block_mode;
        logic full_mode;
        logic word_size;
        logic dst_dec;
        logic src_dec;
    } dfa_ctrl_t;

    localparam dfa_ctrl_t CTRL_RESET = '0;

    typedef struct packed {
        logic [ADDR_W-1:0] source_address_reg;
        logic [ADDR_W-1:0] destination_address_reg;
        logic [CNT_W-1:0] transfer_count;
        logic [ADDR_W-1:0] io_address_reg;
        dfa_ctrl_t ctrl;
        logic busy;
        logic done;
        logic [CNT_W-1:0] rd_left;
        logic [BLK_W-1:0] wr_in_blk;
        logic bus_done;
        logic [BUS_W-1:0] rdata;
        logic col_seen;
    } dfa_state_t;

endpackage : dfa_pkg

// ---- design/dfa_fifo.sv ----
// Data FIFO between the source read side and the destination write side
`timescale 1ns/100ps
module dfa_fifo
    import dfa_pkg::*;
#(
    parameter int W = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } dfa_fifo_state_t;

    dfa_fifo_state_t st;
    dfa_fifo_state_t next_st;
    logic push;
    logic pop;

    assign in_ready = st.cnt != FULL;
    assign out_valid = st.cnt != '0;
    assign out_data = st.mem[st.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data;
            next_st.wp = (st.wp == LAST) ? '0 : st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = (st.rp == LAST) ? '0 : st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        if (!resetn) begin
            next_st.wp = '0;
            next_st.rp = '0;
            next_st.cnt = '0;
        end
    end

    always_ff @(posedge clock) begin
        st <= next_st;
    end

endmodule : dfa_fifo

// ---- design/dfa_channel.sv ----
// Full address DMA channel: registers, transfer engine and DRAM acknowledge
// Behaviour
// - In DRAM burst mode the timing select bit picks acknowledge timing and burst use.
// - With timing select 1, burst is decided by address alone, not bus master.
// - With timing select 1, acknowledge goes low from the first column state.
// - Full address mode runs source and destination halves as one channel.
// - A 24-bit address register per half: source, and destination.
// - Each address is two 16-bit halves; upper 8 bits read zero, ignore writes.
// - Address steps up or down after every byte or word transfer.
// - Address registers keep their contents through reset and standby.
// - Full address mode ignores the I/O address register.
// - A 16-bit count register sets transfers; meaning differs in block mode.
// - Count register keeps its contents through reset and standby.
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps
module dfa_channel
    import dfa_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [REG_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [BUS_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [BUS_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic rd_req,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic rd_ack,
    input wire logic [DATA_W-1:0] rd_data,
    output logic wr_req,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [DATA_W-1:0] wr_data,
    input wire logic wr_ack,
    output logic xfer_word,
    input wire logic dram_burst_mode,
    input wire logic dram_addr_hit,
    input wire logic dram_access,
    input wire logic first_column_state,
    input wire logic master_is_dma,
    output logic burst_allow,
    output logic dma_acknowledge_n,
    output logic busy
);

    dfa_state_t st;
    dfa_state_t next_st;
    logic rd_fire;
    logic wr_fire;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic cnt_zero;
    logic ack_active;
    logic wr_take;
    logic [ADDR_W-1:0] step;

    function automatic logic [HALF_W-1:0] merge16(
        input logic [HALF_W-1:0] old,
        input logic [HALF_W-1:0] wd,
        input logic [1:0] be
    );
        logic [HALF_W-1:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge16

    function automatic logic [ADDR_W-1:0] advance(
        input logic [ADDR_W-1:0] a,
        input logic dec,
        input logic [ADDR_W-1:0] s
    );
        return dec ? a - s : a + s;
    endfunction : advance

    dfa_fifo #(
        .W(DATA_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock(clock),
        .resetn(resetn),
        .in_valid(rd_fire),
        .in_ready(fifo_in_ready),
        .in_data(rd_data),
        .out_valid(fifo_out_valid),
        .out_ready(wr_ack & wr_req),
        .out_data(wr_data)
    );

    // Bus slave answers one cycle after the request is seen
    assign avs_waitrequest = (avs_read | avs_write) & ~st.bus_done;
    assign avs_readdata = st.rdata;
    assign wr_take = avs_write & st.bus_done;
    assign busy = st.busy;
    assign xfer_word = st.ctrl.word_size;
    assign step = st.ctrl.word_size ? STEP_WORD : STEP_BYTE;

    assign rd_req = st.busy & (st.rd_left != '0) & fifo_in_ready;
    assign rd_addr = st.source_address_reg;
    assign rd_fire = rd_req & rd_ack;
    assign wr_req = st.busy & fifo_out_valid;
    // Outside full address mode the destination is the fixed I/O address
    assign wr_addr = st.ctrl.full_mode ? st.destination_address_reg : st.io_address_reg;
    assign wr_fire = wr_req & wr_ack;
    assign cnt_zero = st.ctrl.block_mode ? (st.transfer_count[15:8] == '0)
                                         : (st.transfer_count == '0);

    // DRAM side: burst decision and acknowledge timing
    assign burst_allow = dram_burst_mode & dram_addr_hit
                       & (st.ctrl.ack_timing_select | ~master_is_dma);
    assign ack_active = st.ctrl.ack_timing_select ? (st.col_seen | first_column_state) : 1'b1;
    assign dma_acknowledge_n = ~(dram_access & master_is_dma & ack_active);

    always_comb begin
        next_st = st;
        next_st.bus_done = (avs_read | avs_write) & ~st.bus_done;
        next_st.col_seen = dram_access & (st.col_seen | first_column_state);
        if ((avs_read | avs_write) & ~st.bus_done) begin
            case (avs_address)
                REG_SRC_LO: next_st.rdata = {16'h0000, st.source_address_reg[15:0]};
                REG_SRC_HI: next_st.rdata = {24'h000000, st.source_address_reg[23:16]};
                REG_DST_LO: next_st.rdata = {16'h0000, st.destination_address_reg[15:0]};
                REG_DST_HI: next_st.rdata = {24'h000000, st.destination_address_reg[23:16]};
                REG_COUNT: next_st.rdata = {16'h0000, st.transfer_count};
                REG_IO_ADDR: next_st.rdata = {8'h00, st.io_address_reg};
                REG_CTRL: next_st.rdata = BUS_W'({st.ctrl, 1'b0});
                REG_STATUS: next_st.rdata = BUS_W'({st.done, st.busy});
                default: next_st.rdata = '0;
            endcase
        end
        // Configuration writes are ignored while a transfer runs
        if (wr_take & ~st.busy) begin
            case (avs_address)
                REG_SRC_LO: begin
                    next_st.source_address_reg[15:0] = merge16(st.source_address_reg[15:0],
                        avs_writedata[15:0], avs_byteenable[1:0]);
                end
                REG_SRC_HI: begin
                    if (avs_byteenable[0]) begin
                        next_st.source_address_reg[23:16] = avs_writedata[7:0];
                    end
                end
                REG_DST_LO: begin
                    next_st.destination_address_reg[15:0] = merge16(
                        st.destination_address_reg[15:0], avs_writedata[15:0],
                        avs_byteenable[1:0]);
                end
                REG_DST_HI: begin
                    if (avs_byteenable[0]) begin
                        next_st.destination_address_reg[23:16] = avs_writedata[7:0];
                    end
                end
                REG_COUNT: begin
                    next_st.transfer_count = merge16(st.transfer_count,
                        avs_writedata[15:0], avs_byteenable[1:0]);
                end
                REG_IO_ADDR: begin
                    next_st.io_address_reg[15:0] = merge16(st.io_address_reg[15:0],
                        avs_writedata[15:0], avs_byteenable[1:0]);
                    if (avs_byteenable[2]) begin
                        next_st.io_address_reg[23:16] = avs_writedata[23:16];
                    end
                end
                REG_CTRL: begin
                    if (avs_byteenable[0]) begin
                        next_st.ctrl = avs_writedata[CTL_ATS:CTL_SRC_DEC];
                        if (avs_writedata[CTL_START]) begin
                            next_st.busy = 1'b1;
                            next_st.wr_in_blk = '0;
                            next_st.rd_left = avs_writedata[CTL_BLOCK]
                                ? st.transfer_count[15:8] * st.transfer_count[7:0]
                                : st.transfer_count;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        if (wr_take & (avs_address == REG_STATUS) & avs_byteenable[0]
            & avs_writedata[STS_DONE]) begin
            next_st.done = 1'b0;
        end
        if (rd_fire) begin
            next_st.rd_left = st.rd_left - 1'b1;
            next_st.source_address_reg = advance(st.source_address_reg,
                st.ctrl.src_dec, step);
        end
        if (wr_fire) begin
            if (st.ctrl.full_mode) begin
                next_st.destination_address_reg = advance(st.destination_address_reg,
                    st.ctrl.dst_dec, step);
            end
            if (st.ctrl.block_mode) begin
                if (st.wr_in_blk + 1'b1 == st.transfer_count[7:0]) begin
                    next_st.wr_in_blk = '0;
                    next_st.transfer_count[15:8] = st.transfer_count[15:8] - 1'b1;
                end else begin
                    next_st.wr_in_blk = st.wr_in_blk + 1'b1;
                end
            end else begin
                next_st.transfer_count = st.transfer_count - 1'b1;
            end
        end
        // Completion sets done and wins over a clear in the same cycle
        if (st.busy & cnt_zero & (st.rd_left == '0) & ~fifo_out_valid) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
        end
        // Address, count and I/O address registers are left untouched by reset
        if (!resetn) begin
            next_st.ctrl = CTRL_RESET;
            next_st.busy = 1'b0;
            next_st.done = 1'b0;
            next_st.rd_left = '0;
            next_st.wr_in_blk = '0;
            next_st.bus_done = 1'b0;
            next_st.rdata = '0;
            next_st.col_seen = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        st <= next_st;
    end

    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);

    a_burst_mode_off: assert property (!dram_burst_mode |-> !burst_allow)
        else $error("burst allowed outside burst mode");

    a_ack_ats_off: assert property (
        !st.ctrl.ack_timing_select & dram_access & master_is_dma |-> !dma_acknowledge_n)
        else $error("acknowledge not low for a whole access");

    a_burst_addr_only: assert property (
        st.ctrl.ack_timing_select & dram_burst_mode |-> burst_allow == dram_addr_hit)
        else $error("burst decision depends on more than the address");

    a_ack_from_col: assert property (
        st.ctrl.ack_timing_select & dram_access & master_is_dma & first_column_state
        ##1 dram_access & master_is_dma |-> !dma_acknowledge_n)
        else $error("acknowledge not held low after first column state");

    a_ack_before_col: assert property (
        st.ctrl.ack_timing_select & !st.col_seen & !first_column_state
        |-> dma_acknowledge_n)
        else $error("acknowledge low before first column state");

    a_start_busy: assert property (
        wr_take & !st.busy & avs_address == REG_CTRL & avs_byteenable[0]
        & avs_writedata[CTL_START] |=> st.busy)
        else $error("start write did not launch a transfer");

    a_src_step: assert property (
        rd_fire & !st.ctrl.src_dec & st.ctrl.word_size
        |=> st.source_address_reg == $past(st.source_address_reg) + STEP_WORD)
        else $error("source address did not step by a word");

    a_dst_step: assert property (
        wr_fire & st.ctrl.full_mode & st.ctrl.dst_dec
        |=> st.destination_address_reg == $past(st.destination_address_reg) - $past(step))
        else $error("destination address did not step down");

    a_src_hold: assert property (st.busy & !rd_fire |=> $stable(st.source_address_reg))
        else $error("source address moved without a read");

    a_rsv_read_zero: assert property (
        avs_read & !st.bus_done & avs_address == REG_DST_HI
        |=> avs_readdata[31:8] == '0 && !avs_waitrequest)
        else $error("reserved address bits read nonzero");

    a_io_ignored: assert property (
        wr_req & st.ctrl.full_mode |-> wr_addr == st.destination_address_reg)
        else $error("I/O address used in full address mode");

    a_count_down: assert property (
        wr_fire & !st.ctrl.block_mode |=> st.transfer_count == $past(st.transfer_count) - 1'b1)
        else $error("transfer count did not decrement");

    a_blk_count_down: assert property (
        wr_fire & st.ctrl.block_mode & (st.wr_in_blk + 1'b1 == st.transfer_count[7:0])
        |=> st.transfer_count[15:8] == $past(st.transfer_count[15:8]) - 1'b1)
        else $error("block count did not drop at block end");

    a_regs_kept: assert property (disable iff (1'b0)
        !resetn & st.done |=> st.transfer_count == $past(st.transfer_count)
        && st.source_address_reg == $past(st.source_address_reg))
        else $error("reset changed address or count register");

    a_end_done: assert property (st.busy ##1 !st.busy |-> st.done)
        else $error("transfer ended without done");

    a_end_at_zero: assert property (
        st.busy & !st.ctrl.block_mode & st.transfer_count != '0 |=> st.busy)
        else $error("transfer ended before count reached zero");

endmodule : dfa_channel

// ---- test/dfa_mem_model.sv ----
// Memory partner model answering the channel's read and write requests
`timescale 1ns/100ps
module dfa_mem_model
    import dfa_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic stall,
    input wire logic rd_req,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic rd_ack,
    output logic [DATA_W-1:0] rd_data,
    input wire logic wr_req,
    output logic wr_ack
);
    initial begin
        rd_ack = 1'b0;
        wr_ack = 1'b0;
    end
    // Random pacing; writes held off entirely while stalled
    always @(posedge clock) begin
        rd_ack <= resetn && (($urandom % 3) != 0);
        wr_ack <= resetn && !stall && (($urandom % 4) != 0);
    end
    // Data only valid with acknowledge; inverse pattern otherwise
    assign rd_data = rd_ack ? (rd_addr[15:0] ^ 16'h5a3c) : ~(rd_addr[15:0] ^ 16'h5a3c);
endmodule : dfa_mem_model

// ---- test/testbench.sv ----
// Self-checking bench for the full address DMA channel
`timescale 1ns/100ps
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, x); end end
module testbench
    import dfa_pkg::*;
;
    logic clock = 1'b0, resetn = 1'b0, stall = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, e;
    logic avs_waitrequest, rd_req, rd_ack, wr_req, wr_ack, xfer_word, burst_allow, busy;
    logic [23:0] rd_addr, wr_addr;
    logic [15:0] rd_data, wr_data;
    logic bm = 1'b0, hit = 1'b0, acc = 1'b0, fcs = 1'b0, mdma = 1'b0, ack_n;
    logic [39:0] exp_wr[$], w;
    logic [31:0] exp_rd[$];
    int miscompares = 0, checks_done = 0, reads = 0;
    always #12.5 clock = ~clock;
    dfa_channel DUT (.clock(clock), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data),
        .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .wr_ack(wr_ack),
        .xfer_word(xfer_word), .dram_burst_mode(bm), .dram_addr_hit(hit), .dram_access(acc),
        .first_column_state(fcs), .master_is_dma(mdma), .burst_allow(burst_allow),
        .dma_acknowledge_n(ack_n), .busy(busy));
    dfa_mem_model mem (.clock(clock), .resetn(resetn), .stall(stall), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .wr_req(wr_req),
        .wr_ack(wr_ack));
    // Results are matched against the oldest expectation
    always @(posedge clock) begin
        if (rd_req && rd_ack) reads++;
        if (avs_read && avs_waitrequest === 1'b0) begin
            e = (exp_rd.size() > 0) ? exp_rd.pop_front() : ~avs_readdata;
            `CHK(avs_readdata, e)
        end
        if (wr_req && wr_ack) begin
            w = (exp_wr.size() > 0) ? exp_wr.pop_front() : ~{wr_addr, wr_data};
            `CHK({wr_addr, wr_data}, w)
        end
    end
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [31:0] x);
        exp_rd.push_back(x);
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    task automatic xfer(input bit dec, input bit word, input bit full, input bit blk,
        input logic [15:0] cnt);
        logic [23:0] s, d, st, a, b;
        int k, n;
        s = 24'($urandom);
        d = 24'($urandom);
        st = word ? 24'h2 : 24'h1;
        n = blk ? cnt[15:8] * cnt[7:0] : cnt;
        bus(1, REG_SRC_LO, {16'h0, s[15:0]});
        bus(1, REG_SRC_HI, {24'h0, s[23:16]});
        bus(1, REG_DST_LO, {16'h0, d[15:0]});
        bus(1, REG_DST_HI, {24'h0, d[23:16]});
        bus(1, REG_COUNT, {16'h0, cnt});
        bus(1, REG_IO_ADDR, {8'h0, ~d});
        bus(1, REG_STATUS, 32'h2);
        for (int i = 0; i < n; i++) begin
            a = dec ? d - 24'(i) * st : d + 24'(i) * st;
            b = dec ? s - 24'(i) * st : s + 24'(i) * st;
            exp_wr.push_back({full ? a : ~d, b[15:0] ^ 16'h5a3c});
        end
        stall <= 1'b1;
        reads = 0;
        bus(1, REG_CTRL, 32'h1 | (full ? 32'h10 : 32'h0) | (blk ? 32'h20 : 32'h0)
            | (dec ? 32'h6 : 32'h0) | (word ? 32'h8 : 32'h0));
        repeat (30) @(posedge clock);
        `CHK(reads, (n < FIFO_DEPTH) ? n : FIFO_DEPTH)
        `CHK(xfer_word, word)
        stall <= 1'b0;
        k = 0;
        while ((busy !== 1'b0 || exp_wr.size() > 0) && k < 2000) begin
            @(posedge clock);
            k++;
        end
        `CHK(busy, 1'b0)
        `CHK(exp_wr.size(), 0)
        s = dec ? s - 24'(n) * st : s + 24'(n) * st;
        if (full) d = dec ? d - 24'(n) * st : d + 24'(n) * st;
        rd(REG_STATUS, 32'h2);
        rd(REG_COUNT, {24'h0, blk ? cnt[7:0] : 8'h00});
        rd(REG_SRC_LO, {16'h0, s[15:0]});
        rd(REG_DST_HI, {24'h0, d[23:16]});
        $display("transfer test dec=%0d word=%0d full=%0d blk=%0d n=%0d done", dec, word,
            full, blk, n);
    endtask : xfer
    initial begin
        void'($urandom(14883));
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        rd(REG_CTRL, 32'h0);
        rd(REG_STATUS, 32'h0);
        bus(1, REG_SRC_HI, 32'hffffffff);
        rd(REG_SRC_HI, 32'h000000ff);
        bus(1, 4'h9, 32'hffffffff);
        rd(4'h9, 32'h0);
        $display("register test done");
        for (int i = 0; i < 64; i++) begin
            if (i == 32) bus(1, REG_CTRL, 32'h40);
            @(posedge clock);
            {bm, hit, acc, fcs, mdma} <= 5'(i);
            @(negedge clock);
            `CHK(burst_allow, bm & hit & (i >= 32 | !mdma))
            if (i < 32) `CHK(ack_n, !(acc & mdma))
        end
        @(posedge clock);
        {bm, hit, acc, fcs, mdma} <= 5'b00000;
        @(posedge clock);
        {bm, hit, acc, fcs, mdma} <= 5'b11101;
        @(negedge clock);
        `CHK(ack_n, 1'b1)
        @(posedge clock);
        fcs <= 1'b1;
        @(negedge clock);
        `CHK(ack_n, 1'b0)
        @(posedge clock);
        fcs <= 1'b0;
        @(negedge clock);
        `CHK(ack_n, 1'b0)
        @(posedge clock);
        acc <= 1'b0;
        @(negedge clock);
        `CHK(ack_n, 1'b1)
        $display("acknowledge test done");
        xfer(0, 0, 1, 0, 16'd6);
        xfer(1, 1, 1, 0, 16'd5);
        xfer(0, 1, 1, 0, 16'd1);
        xfer(0, 0, 1, 1, 16'h0203);
        xfer(1, 0, 0, 0, 16'd3);
        bus(1, REG_SRC_LO, 32'h1234);
        bus(1, REG_COUNT, 32'h7);
        @(posedge clock);
        resetn <= 1'b0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        rd(REG_SRC_LO, 32'h1234);
        rd(REG_COUNT, 32'h7);
        rd(REG_CTRL, 32'h0);
        $display("reset retention test done");
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        conclude();
    end
endmodule : testbench
